// *** hw/switch_port_mac.sv ***
`timescale 1ns/1ps
`include "sw_port_regs.svh"
module switch_port_mac
    import sw_port_pkg::*;
#(
    parameter int STORM_CYC_FAST = `STORM_MS_FAST * 1000000 / `CLK_NS,
    parameter int STORM_CYC_SLOW = `STORM_MS_SLOW * 1000000 / `CLK_NS,
    parameter logic [1:0] PORT_NUM = 2'h1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    input wire logic rx_err,
    input wire logic [1:0] lkp_port,
    input wire logic dst_busy,
    input wire logic rxq_full,
    output logic fwd_valid,
    output logic [7:0] fwd_buf,
    output logic [10:0] fwd_len,
    output logic [1:0] fwd_port,
    input wire logic tx_req,
    input wire logic [7:0] tx_buf,
    input wire logic [10:0] tx_len,
    output logic tx_busy,
    output logic tx_done,
    output logic tx_drop,
    input wire logic mii_carrier_sense,
    input wire logic mii_collision,
    output logic mii_transmit_enable,
    output logic [7:0] mii_tx_data
);
    function automatic logic [7:0] byte_of(input logic [47:0] v, input logic [2:0] n);
        case (n)
            3'h0: byte_of = v[47:40];
            3'h1: byte_of = v[39:32];
            3'h2: byte_of = v[31:24];
            3'h3: byte_of = v[23:16];
            3'h4: byte_of = v[15:8];
            default: byte_of = v[7:0];
        endcase
    endfunction

    logic [31:0] ctrl_r;
    logic [7:0] storm_lim_r;
    logic [47:0] mac_r;
    logic [15:0] rx_drop_cnt_r, tx_drop_cnt_r;
    logic [1:0] crs_sync_r, col_sync_r;
    logic [10:0] rx_cnt_r;
    logic da_bc_r, da_mc_r, rx_ovf_r;
    logic [47:0] sa_r;
    logic [15:0] type_r, op_r, ptime_r;
    buf_idx_t rx_start_r;
    logic [8:0] free_r;
    logic [15:0] pause_q_r;
    logic [7:0] pause_sub_r;
    logic cong_r, pp_pend_r;
    logic [15:0] pp_val_r;
    logic [24:0] st_time_r;
    logic [7:0] storm_cnt_r;
    tx_state_e state_r;
    logic tx_pend_r;
    buf_idx_t tx_buf_r;
    frame_len_t tx_len_r, byte_idx_r;
    logic [1:0] sub_r;
    logic [8:0] tx_time_r;
    logic [4:0] coll_cnt_r;
    logic [17:0] bo_cnt_r;
    logic [10:0] bp_cnt_r;
    logic [5:0] ipg_cnt_r;
    logic coll_seen_r;
    logic [9:0] lfsr_r;
    logic [7:0] mem_q;

    wire fdx = ctrl_r[`CTRL_FDX];
    wire agr = ctrl_r[`CTRL_AGR];
    wire exdrop = ctrl_r[`CTRL_EXDROP];
    wire bp_en = ctrl_r[`CTRL_BP];
    wire fc_en = ctrl_r[`CTRL_FC];
    wire [1:0] max_sel = ctrl_r[`CTRL_MAX+1:`CTRL_MAX];
    wire crs_s = crs_sync_r[1];
    wire col_s = col_sync_r[1];

    // Register decode
    wire sel_ctrl = reg_addr == `REG_CTRL;
    wire sel_storm = reg_addr == `REG_STORM;
    wire sel_mlo = reg_addr == `REG_MAC_LO;
    wire sel_mhi = reg_addr == `REG_MAC_HI;
    wire sel_stat = reg_addr == `REG_STATUS;
    wire sel_rxd = reg_addr == `REG_RX_DROP;
    wire sel_txd = reg_addr == `REG_TX_DROP;
    wire [31:0] status_w = {18'h00000, mii_transmit_enable, state_r == TX_BP, cong_r,
                            pause_q_r != 16'h0000, tx_pend_r, free_r};
    wire [31:0] rd_mux = sel_ctrl ? ctrl_r :
                         sel_storm ? {24'h000000, storm_lim_r} :
                         sel_mlo ? mac_r[31:0] :
                         sel_mhi ? {16'h0000, mac_r[47:32]} :
                         sel_stat ? status_w :
                         sel_rxd ? {16'h0000, rx_drop_cnt_r} :
                         sel_txd ? {16'h0000, tx_drop_cnt_r} : 32'h0000_0000;

    // Receive field capture by byte position
    wire in_da = rx_cnt_r < 11'h006;
    wire in_sa = !in_da && rx_cnt_r < 11'h00C;
    wire in_type = rx_cnt_r == 11'h00C || rx_cnt_r == 11'h00D;
    wire in_op = rx_cnt_r == 11'h00E || rx_cnt_r == 11'h00F;
    wire in_time = rx_cnt_r == 11'h010 || rx_cnt_r == 11'h011;
    wire ovf_now = {5'h00, rx_cnt_r[10:7]} >= free_r;
    wire ovf_any = rx_ovf_r | ovf_now;
    wire rx_end = rx_valid & rx_last;
    wire [10:0] rx_len = rx_cnt_r + 11'h001;
    wire is_vlan = type_r == `TYPE_VLAN;
    wire [10:0] max_base = max_sel == 2'h0 ? `MAX_LEN0 :
                           max_sel == 2'h1 ? `MAX_LEN1 : `MAX_LEN2;
    wire [10:0] max_len = max_base + (is_vlan ? `VLAN_ADD : 11'h000);
    wire len_bad = rx_len < `MIN_LEN || rx_len > max_len || rx_cnt_r == 11'h7FF;
    wire rx_bad = rx_err | len_bad | ovf_any;
    wire is_pause = type_r == `TYPE_PAUSE && op_r == `OP_PAUSE;
    wire is_local = lkp_port == PORT_NUM;
    wire saf_hit = ctrl_r[`CTRL_SAF] && sa_r == mac_r;
    wire storm_hit = ctrl_r[`CTRL_STORM] & (da_bc_r | (ctrl_r[`CTRL_MCAST] & da_mc_r));
    wire storm_over = storm_hit && storm_cnt_r >= storm_lim_r;
    wire rx_drop = rx_bad | is_pause | is_local | saf_hit | storm_over;
    wire admit = rx_end & ~rx_drop;
    wire pause_load = rx_end & ~rx_bad & is_pause & fdx & fc_en;
    wire [11:0] rx_len_up = {1'b0, rx_len} + 12'h07F;
    wire [4:0] alloc_n = admit ? rx_len_up[11:7] : 5'h00;
    wire pool_we = rx_valid & ~ovf_any;
    wire [14:0] wr_addr = {rx_start_r, 7'h00} + {4'h0, rx_cnt_r};

    // Flow control trigger with hysteresis
    wire free_low = free_r < `FC_LOW;
    wire cong_set = (rx_end & ~rx_drop & (dst_busy | free_low)) | rxq_full;
    wire cong_clr = ~rxq_full & ~dst_busy & (free_r >= `FC_HIGH);
    wire cong_nxt = cong_set | (cong_r & ~cong_clr);
    wire fc_fdx = fdx & fc_en;
    wire paused = pause_q_r != 16'h0000;
    wire bp_need = ~fdx & bp_en & cong_r;
    wire st_wrap = st_time_r == (ctrl_r[`CTRL_SPD10] ? 25'(STORM_CYC_SLOW - 1)
                                                    : 25'(STORM_CYC_FAST - 1));

    // Transmit side
    wire ipg_ok = ipg_cnt_r == 6'(`IPG_CYC);
    wire ipg_hold = mii_transmit_enable | (coll_seen_r & crs_s);
    wire can_go = ipg_ok & (fdx | ~crs_s);
    wire in_frame = state_r == TX_DATA || state_r == TX_PAUSE;
    wire [10:0] cur_len = state_r == TX_PAUSE ? `PAUSE_LEN : tx_len_r;
    wire byte_last = sub_r == 2'(`BYTE_CYC - 1);
    wire frame_end = byte_idx_r == cur_len && sub_r == 2'h0;
    wire coll_hit = state_r == TX_DATA && col_s && mii_transmit_enable && !fdx;
    wire late = tx_time_r >= 9'(`SLOT_CYC);
    wire [4:0] coll_n = coll_cnt_r + 5'h01;
    wire excess = coll_n == `EXC_COLL;
    wire [3:0] bo_lim = agr ? `BO_LIM_AGR : `BO_LIM_STD;
    wire [3:0] bo_k = coll_n > {1'b0, bo_lim} ? bo_lim : coll_n[3:0];
    wire [10:0] bo_mask = (11'h001 << bo_k) - 11'h001;
    wire [9:0] bo_slots = lfsr_r & bo_mask[9:0];
    wire tx_drop_now = coll_hit & (late | (excess & exdrop));
    wire tx_ok_now = state_r == TX_DATA && frame_end;
    wire [11:0] tx_len_up = {1'b0, tx_len_r} + 12'h07F;
    wire [4:0] rel_n = (tx_drop_now | tx_ok_now) ? tx_len_up[11:7] : 5'h00;
    wire [14:0] rd_addr = {tx_buf_r, 7'h00} + {4'h0, byte_idx_r};
    wire [5:0] pidx = byte_idx_r[5:0];
    wire [7:0] pause_byte = pidx < 6'h06 ? byte_of(`PAUSE_DA, pidx[2:0]) :
                            pidx < 6'h0C ? byte_of(mac_r, 3'(pidx - 6'h06)) :
                            pidx == 6'h0C ? 8'(`TYPE_PAUSE >> 8) :
                            pidx == 6'h0D ? 8'(`TYPE_PAUSE & 16'h00FF) :
                            pidx == 6'h0F ? 8'(`OP_PAUSE & 16'h00FF) :
                            pidx == 6'h10 ? pp_val_r[15:8] :
                            pidx == 6'h11 ? pp_val_r[7:0] : 8'h00;
    wire start_pause = state_r == TX_IDLE && pp_pend_r && fdx && can_go;
    wire start_data = state_r == TX_IDLE && !start_pause && tx_pend_r && !paused && can_go;

    pool_ram u_pool (
        .sys_clk(sys_clk),
        .wr_en(pool_we),
        .wr_addr(wr_addr),
        .wr_data(rx_data),
        .rd_addr(rd_addr),
        .rd_data(mem_q)
    );

    // Pins from the PHY are asynchronous
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            crs_sync_r <= 2'h0;
            col_sync_r <= 2'h0;
        end else begin
            crs_sync_r <= {crs_sync_r[0], mii_carrier_sense};
            col_sync_r <= {col_sync_r[0], mii_collision};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_r <= `CTRL_RST;
            storm_lim_r <= `STORM_RST;
            mac_r <= 48'h0;
        end else if (reg_wr) begin
            if (sel_ctrl) begin
                ctrl_r <= reg_wdata & `CTRL_MASK;
            end else if (sel_storm) begin
                storm_lim_r <= reg_wdata[7:0];
            end else if (sel_mlo) begin
                mac_r[31:0] <= reg_wdata;
            end else if (sel_mhi) begin
                mac_r[47:32] <= reg_wdata[15:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 32'h0;
        end
    end

    // Receive capture and admission
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rx_cnt_r <= 11'h0;
            rx_ovf_r <= 1'b0;
            da_bc_r <= 1'b0;
            da_mc_r <= 1'b0;
            sa_r <= 48'h0;
            type_r <= 16'h0;
            op_r <= 16'h0;
            ptime_r <= 16'h0;
        end else if (rx_valid) begin
            rx_cnt_r <= rx_last ? 11'h0 : rx_cnt_r + {10'h0, rx_cnt_r != 11'h7FF};
            rx_ovf_r <= rx_last ? 1'b0 : ovf_any;
            if (rx_cnt_r == 11'h0) begin
                da_mc_r <= rx_data[0];
            end
            if (in_da) begin
                da_bc_r <= (rx_data == 8'hFF) & (da_bc_r | rx_cnt_r == 11'h0);
            end
            if (in_sa) begin
                sa_r <= {sa_r[39:0], rx_data};
            end
            if (in_type) begin
                type_r <= {type_r[7:0], rx_data};
            end
            if (in_op) begin
                op_r <= {op_r[7:0], rx_data};
            end
            if (in_time) begin
                ptime_r <= {ptime_r[7:0], rx_data};
            end
        end
    end

    // Announce only complete, admitted frames
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fwd_valid <= 1'b0;
            fwd_buf <= 8'h0;
            fwd_len <= 11'h0;
            fwd_port <= 2'h0;
            rx_start_r <= 8'h0;
            free_r <= `NUM_BUFS;
            rx_drop_cnt_r <= 16'h0;
        end else begin
            fwd_valid <= admit;
            if (admit) begin
                fwd_buf <= rx_start_r;
                fwd_len <= rx_len;
                fwd_port <= lkp_port;
            end
            rx_start_r <= rx_start_r + {3'h0, alloc_n};
            free_r <= free_r + {4'h0, rel_n} - {4'h0, alloc_n};
            if (rx_end && rx_drop && rx_drop_cnt_r != 16'hFFFF) begin
                rx_drop_cnt_r <= rx_drop_cnt_r + 16'h0001;
            end
        end
    end

    // Storm interval; a hit in the clearing cycle still counts
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_time_r <= 25'h0;
            storm_cnt_r <= 8'h0;
        end else begin
            st_time_r <= st_wrap ? 25'h0 : st_time_r + 25'h1;
            if (st_wrap) begin
                storm_cnt_r <= {7'h0, rx_end & storm_hit & ~rx_bad};
            end else if (rx_end && storm_hit && !rx_bad && !storm_over) begin
                storm_cnt_r <= storm_cnt_r + 8'h01;
            end
        end
    end

    // Pause timer in quanta of one slot time
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pause_q_r <= 16'h0;
            pause_sub_r <= 8'h0;
        end else if (pause_load) begin
            pause_q_r <= ptime_r;
            pause_sub_r <= 8'h0;
        end else if (paused) begin
            pause_sub_r <= pause_sub_r + 8'h01;
            if (pause_sub_r == 8'(`SLOT_CYC - 1)) begin
                pause_q_r <= pause_q_r - 16'h0001;
            end
        end
    end

    // Congestion edge queues an outgoing pause; new edge wins over send
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cong_r <= 1'b0;
            pp_pend_r <= 1'b0;
            pp_val_r <= 16'h0;
        end else begin
            cong_r <= cong_nxt;
            if (fc_fdx && cong_nxt != cong_r) begin
                pp_pend_r <= 1'b1;
                pp_val_r <= cong_nxt ? `PAUSE_MAX : 16'h0000;
            end else if (start_pause) begin
                pp_pend_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ipg_cnt_r <= 6'(`IPG_CYC);
            lfsr_r <= 10'h001;
        end else begin
            ipg_cnt_r <= ipg_hold ? 6'h00 : ipg_cnt_r + {5'h00, !ipg_ok};
            lfsr_r <= {lfsr_r[8:0], lfsr_r[9] ^ lfsr_r[6]};
        end
    end

    // Egress frame slot; switch side must wait while busy
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_pend_r <= 1'b0;
            tx_buf_r <= 8'h0;
            tx_len_r <= 11'h0;
            tx_busy <= 1'b0;
            tx_done <= 1'b0;
            tx_drop <= 1'b0;
            tx_drop_cnt_r <= 16'h0;
        end else begin
            tx_done <= tx_ok_now;
            tx_drop <= tx_drop_now;
            if (tx_ok_now || tx_drop_now) begin
                tx_pend_r <= 1'b0;
                tx_busy <= 1'b0;
            end else if (tx_req && !tx_pend_r) begin
                tx_pend_r <= 1'b1;
                tx_busy <= 1'b1;
                tx_buf_r <= tx_buf;
                tx_len_r <= tx_len;
            end
            if (tx_drop_now && tx_drop_cnt_r != 16'hFFFF) begin
                tx_drop_cnt_r <= tx_drop_cnt_r + 16'h0001;
            end
        end
    end

    // Transmit sequencer; jam is left to the PHY
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= TX_IDLE;
            mii_transmit_enable <= 1'b0;
            mii_tx_data <= 8'h00;
            byte_idx_r <= 11'h0;
            sub_r <= 2'h0;
            tx_time_r <= 9'h0;
            coll_cnt_r <= 5'h0;
            bo_cnt_r <= 18'h0;
            bp_cnt_r <= 11'h0;
            coll_seen_r <= 1'b0;
        end else begin
            case (state_r)
                TX_IDLE: begin
                    byte_idx_r <= 11'h0;
                    sub_r <= 2'h0;
                    tx_time_r <= 9'h0;
                    bp_cnt_r <= 11'h0;
                    if (start_pause) begin
                        state_r <= TX_PAUSE;
                        coll_seen_r <= 1'b0;
                    end else if (start_data) begin
                        state_r <= TX_DATA;
                        coll_seen_r <= 1'b0;
                    end else if (bp_need && ipg_ok) begin
                        state_r <= TX_BP;
                    end
                end
                TX_DATA, TX_PAUSE: begin
                    sub_r <= byte_last ? 2'h0 : sub_r + 2'h1;
                    byte_idx_r <= byte_idx_r + {10'h0, byte_last};
                    tx_time_r <= tx_time_r + {8'h0, !late && mii_transmit_enable};
                    if (coll_hit) begin
                        mii_transmit_enable <= 1'b0;
                        coll_seen_r <= 1'b1;
                        if (late || (excess && exdrop)) begin
                            state_r <= TX_IDLE;
                            coll_cnt_r <= 5'h0;
                        end else begin
                            state_r <= TX_BACKOFF;
                            coll_cnt_r <= excess ? 5'h0 : coll_n;
                            bo_cnt_r <= 18'(bo_slots * `SLOT_CYC);
                        end
                    end else if (frame_end) begin
                        mii_transmit_enable <= 1'b0;
                        state_r <= TX_IDLE;
                        if (state_r == TX_DATA) begin
                            coll_cnt_r <= 5'h0;
                        end
                    end else if (sub_r == 2'h1) begin
                        // Read data lags the address by one cycle
                        mii_transmit_enable <= 1'b1;
                        mii_tx_data <= state_r == TX_PAUSE ? pause_byte : mem_q;
                    end
                end
                TX_BACKOFF: begin
                    bo_cnt_r <= bo_cnt_r - {17'h0, bo_cnt_r != 18'h0};
                    if (bo_cnt_r == 18'h0) begin
                        state_r <= TX_IDLE;
                    end
                end
                TX_BP: begin
                    // Collisions are ignored: carrier simply stays up
                    mii_transmit_enable <= 1'b1;
                    mii_tx_data <= `PREAMBLE;
                    bp_cnt_r <= bp_cnt_r + 11'h001;
                    if (!bp_need || (tx_pend_r && !paused)) begin
                        mii_transmit_enable <= 1'b0;
                        state_r <= TX_IDLE;
                    end else if (bp_cnt_r == 11'(`BP_ON_CYC - 1)) begin
                        mii_transmit_enable <= 1'b0;
                        bp_cnt_r <= 11'h0;
                        state_r <= TX_BP_GAP;
                    end
                end
                TX_BP_GAP: begin
                    bp_cnt_r <= bp_cnt_r + 11'h001;
                    if (!bp_need || (tx_pend_r && !paused)) begin
                        state_r <= TX_IDLE;
                    end else if (bp_cnt_r == 11'(`BP_GAP_CYC - 1)) begin
                        bp_cnt_r <= 11'h0;
                        state_r <= TX_BP;
                    end
                end
                default: begin
                    state_r <= TX_IDLE;
                    mii_transmit_enable <= 1'b0;
                end
            endcase
        end
    end
endmodule

// *** hw/sw_port_regs.svh ***
`ifndef SW_PORT_REGS_SVH
`define SW_PORT_REGS_SVH
`define CLK_NS 20
`define BIT_NS 10
`define IPG_BITS 96
`define IPG_CYC ((`IPG_BITS * `BIT_NS + `CLK_NS - 1) / `CLK_NS)
`define SLOT_BITS 512
`define SLOT_CYC (`SLOT_BITS * `BIT_NS / `CLK_NS)
`define BYTE_CYC (8 * `BIT_NS / `CLK_NS)
`define STORM_MS_FAST 67
`define STORM_MS_SLOW 500
`define BP_ON_NS 40000
`define BP_ON_CYC (`BP_ON_NS / `CLK_NS)
`define BP_GAP_NS 960
`define BP_GAP_CYC ((`BP_GAP_NS + `CLK_NS - 1) / `CLK_NS)
`define MIN_LEN 11'h040
`define MAX_LEN0 11'h5EE
`define MAX_LEN1 11'h600
`define MAX_LEN2 11'h77C
`define VLAN_ADD 11'h004
`define PAUSE_LEN 11'h03C
`define POOL_AW 15
`define NUM_BUFS 9'h100
`define FC_LOW 9'h020
`define FC_HIGH 9'h040
`define EXC_COLL 5'h10
`define BO_LIM_STD 4'hA
`define BO_LIM_AGR 4'h3
`define TYPE_PAUSE 16'h8808
`define OP_PAUSE 16'h0001
`define TYPE_VLAN 16'h8100
`define PAUSE_MAX 16'hFFFF
`define PAUSE_DA 48'h0180_C200_0001
`define PREAMBLE 8'h55
`define REG_CTRL 8'h00
`define REG_STORM 8'h04
`define REG_MAC_LO 8'h08
`define REG_MAC_HI 8'h0C
`define REG_STATUS 8'h10
`define REG_RX_DROP 8'h14
`define REG_TX_DROP 8'h18
`define CTRL_FDX 0
`define CTRL_AGR 1
`define CTRL_EXDROP 2
`define CTRL_BP 3
`define CTRL_STORM 4
`define CTRL_MCAST 5
`define CTRL_SAF 6
`define CTRL_SPD10 7
`define CTRL_MAX 8
`define CTRL_FC 10
`define CTRL_MASK 32'h0000_07FF
`define CTRL_RST 32'h0000_0405
`define STORM_RST 8'h63
`endif

// *** hw/sw_port_pkg.sv ***
package sw_port_pkg;
    typedef enum logic [5:0] {
        TX_IDLE = 6'h01,
        TX_DATA = 6'h02,
        TX_PAUSE = 6'h04,
        TX_BACKOFF = 6'h08,
        TX_BP = 6'h10,
        TX_BP_GAP = 6'h20
    } tx_state_e;
    typedef logic [7:0] buf_idx_t;
    typedef logic [10:0] frame_len_t;
endpackage

// *** hw/pool_ram.sv ***
`timescale 1ns/1ps
`include "sw_port_regs.svh"
module pool_ram (
    input wire logic sys_clk,
    input wire logic wr_en,
    input wire logic [`POOL_AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [`POOL_AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [0:(1 << `POOL_AW)-1];

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// *** bench/port_chk.sv ***
`timescale 1ns/1ps
module port_chk #(parameter logic [1:0] PORT_NUM = 2'h1) (
    input wire logic sys_clk, rst, rx_valid, rx_last, rx_err, fwd_valid,
    input wire logic tx_done, mii_transmit_enable,
    input wire logic [1:0] lkp_port,
    input wire logic [10:0] fwd_len
);
    logic [10:0] cnt_r;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Bytes before the current one; frames stay under the wrap
    always_ff @(posedge sys_clk) begin
        if (rst || (rx_valid && rx_last)) cnt_r <= 11'h000;
        else if (rx_valid) cnt_r <= cnt_r + 11'h001;
    end
    property p_err; rx_valid && rx_last && rx_err |=> !fwd_valid; endproperty
    a_err: assert property (p_err) else $error("bad frame forwarded");
    property p_loc; rx_valid && rx_last && lkp_port == PORT_NUM |=> !fwd_valid; endproperty
    a_loc: assert property (p_loc) else $error("local frame forwarded");
    property p_saf; fwd_valid |-> $past(rx_valid && rx_last); endproperty
    a_saf: assert property (p_saf) else $error("forward before last byte");
    property p_len; fwd_valid |-> fwd_len == $past(cnt_r) + 11'h001; endproperty
    a_len: assert property (p_len) else $error("forward length wrong");
    property p_min; rx_valid && rx_last && cnt_r < 11'h03F |=> !fwd_valid; endproperty
    a_min: assert property (p_min) else $error("runt forwarded");
    property p_max; rx_valid && rx_last && cnt_r > 11'h77F |=> !fwd_valid; endproperty
    a_max: assert property (p_max) else $error("oversize forwarded");
    property p_ipg; $fell(mii_transmit_enable) |-> !mii_transmit_enable throughout ##47 1'b1;
    endproperty
    a_ipg: assert property (p_ipg) else $error("gap too short");
    property p_done; tx_done |-> !mii_transmit_enable && $past(mii_transmit_enable, 2); endproperty
    a_done: assert property (p_done) else $error("done not after enable end");
endmodule
bind switch_port_mac port_chk #(.PORT_NUM(PORT_NUM)) u_chk (.sys_clk(sys_clk), .rst(rst),
    .rx_valid(rx_valid), .rx_last(rx_last), .rx_err(rx_err), .fwd_valid(fwd_valid),
    .tx_done(tx_done), .mii_transmit_enable(mii_transmit_enable), .lkp_port(lkp_port),
    .fwd_len(fwd_len));

// *** bench/link_partner.sv ***
`timescale 1ns/1ps
module link_partner (
    input wire logic sys_clk, mii_transmit_enable, late_coll,
    output logic mii_carrier_sense, mii_collision
);
    logic [9:0] on_r;
    always_ff @(posedge sys_clk) begin
        on_r <= mii_transmit_enable ? on_r + 10'h001 : 10'h000;
    end
    // Collide only when told, well past the slot, so no retry is legal
    assign mii_collision = late_coll && on_r > 10'h12C;
    assign mii_carrier_sense = mii_transmit_enable || mii_collision;
endmodule

// *** bench/switch_port_mac_tb.sv ***
`timescale 1ns/1ps
`include "sw_port_regs.svh"
module switch_port_mac_tb import sw_port_pkg::*;;
    typedef struct {int len; bit p, e; logic [1:0] lk; bit ex;} row_s;
    row_s rows[8] = '{'{64, 0, 0, 2'h2, 1}, '{63, 0, 0, 2'h2, 0}, '{64, 0, 1, 2'h2, 0},
        '{64, 1, 0, 2'h2, 0}, '{64, 0, 0, 2'h1, 0}, '{1518, 0, 0, 2'h0, 1},
        '{1519, 0, 0, 2'h2, 0}, '{1921, 0, 0, 2'h2, 0}};
    logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, rx_valid = 0, rx_last = 0, rx_err = 0;
    logic tx_req = 0, late_coll = 0, fwd_valid, tx_busy, tx_done, tx_drop, crs, col, te, hi;
    logic [7:0] reg_addr = 0, rx_data = 0, tx_buf = 0, fwd_buf, txd, fb[8];
    logic [31:0] reg_wdata = 0, reg_rdata;
    logic [1:0] lkp_port = 0, fwd_port;
    frame_len_t tx_len = 0, fwd_len;
    int n_tests = 0, bad_count = 0, k;
    logic busy = 0;
    switch_port_mac #(.STORM_CYC_FAST(200), .STORM_CYC_SLOW(400)) uut (.sys_clk(sys_clk),
        .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_last(rx_last), .rx_err(rx_err), .lkp_port(lkp_port), .dst_busy(busy),
        .rxq_full(1'b0), .fwd_valid(fwd_valid), .fwd_buf(fwd_buf), .fwd_len(fwd_len),
        .fwd_port(fwd_port), .tx_req(tx_req), .tx_buf(tx_buf), .tx_len(tx_len),
        .tx_busy(tx_busy), .tx_done(tx_done), .tx_drop(tx_drop), .mii_carrier_sense(crs),
        .mii_collision(col), .mii_transmit_enable(te), .mii_tx_data(txd));
    link_partner lp (.sys_clk(sys_clk), .mii_transmit_enable(te), .late_coll(late_coll),
        .mii_carrier_sense(crs), .mii_collision(col));
    initial forever #10 sys_clk = ~sys_clk;
    task automatic summarize();
        $display("tests %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic wt(string nm, bit ok);
        chk(nm, 1, ok);
        if (!ok) summarize();
    endtask
    function automatic logic [7:0] fbyte(int i, bit p);
        logic [143:0] w;
        w = {`PAUSE_DA, 48'h0000_0000_0000, `TYPE_PAUSE, `OP_PAUSE, 16'h0001};
        if (!p) return (i == 0) ? 8'h02 : 8'(i);
        return (i < 18) ? w[143 - 8 * i -: 8] : 8'h00;
    endfunction
    task automatic rx_frame(int len, bit p, bit e, logic [1:0] lk);
        for (int i = 0; i < len; i++) begin
            rx_valid <= 1'b1;
            rx_data <= fbyte(i, p);
            rx_last <= (i == len - 1);
            rx_err <= e;
            lkp_port <= lk;
            @(posedge sys_clk);
        end
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
    endtask
    task automatic bus(bit w, logic [7:0] a, logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 if (!w) chk("reg_rdata", d, reg_rdata);
        @(posedge sys_clk);
    endtask
    // Enable must stay low for n edges
    task automatic hold(int n);
        hi = 0;
        repeat (n) @(posedge sys_clk) hi = hi | te;
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        foreach (rows[r]) begin
            rx_frame(rows[r].len, rows[r].p, rows[r].e, rows[r].lk);
            #1 chk("fwd_valid", rows[r].ex, fwd_valid);
            if (rows[r].ex) chk("fwd_len", rows[r].len, fwd_len);
            if (rows[r].ex) chk("fwd_port", rows[r].lk, fwd_port);
            fb[r] = fwd_buf;
            @(posedge sys_clk);
        end
        chk("fwd_buf", 8'h01, fb[5]);
        $display("test frame table done");
        bus(0, `REG_CTRL, 32'h0000_0405);
        bus(0, `REG_STORM, 32'h0000_0063);
        bus(0, 8'h40, 32'h0000_0000);
        $display("test registers done");
        rx_frame(64, 1, 0, 2'h2);
        tx_buf <= fb[0];
        tx_len <= 11'h040;
        tx_req <= 1'b1;
        @(posedge sys_clk) tx_req <= 1'b0;
        hold(200);
        chk("te while paused", 0, hi);
        chk("tx_busy", 1, tx_busy);
        for (k = 0; k < 400 && te !== 1'b1; k++) @(posedge sys_clk) #1;
        wt("te after pause", te === 1'b1);
        chk("first byte", 8'h02, txd);
        for (k = 0; k < 400 && tx_done !== 1'b1; k++) @(posedge sys_clk) #1;
        wt("tx_done", tx_done === 1'b1);
        chk("tx_busy done", 0, tx_busy);
        busy <= 1'b1;
        rx_frame(64, 0, 0, 2'h2);
        for (k = 0; k < 400 && te !== 1'b1; k++) @(posedge sys_clk) #1;
        wt("pause out", te === 1'b1);
        chk("pause byte", 8'h01, txd);
        busy <= 1'b0;
        for (k = 0; k < 400 && te; k++) @(posedge sys_clk) #1;
        wt("pause end", te === 1'b0);
        $display("test pause and egress done");
        bus(1, `REG_CTRL, 32'h0000_0404);
        late_coll <= 1'b1;
        tx_buf <= fb[5];
        tx_len <= 11'h5EE;
        tx_req <= 1'b1;
        @(posedge sys_clk) tx_req <= 1'b0;
        for (k = 0; k < 400 && te !== 1'b1; k++) @(posedge sys_clk) #1;
        chk("gap", 1, k >= 44);
        wt("te half duplex", te === 1'b1);
        for (k = 0; k < 1000 && tx_drop !== 1'b1; k++) @(posedge sys_clk) #1;
        wt("tx_drop", tx_drop === 1'b1);
        hold(300);
        chk("no retry", 0, hi);
        $display("test late collision done");
        summarize();
    end
endmodule
